//--- design/core_status_pkg.sv
// Package: offsets, field layout, reset values and types of the status mode bits
package core_status_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [31:0] STATUS_WORD_OFFSET = 32'h0000_0000;
    localparam logic [31:0] MODE_WORD_OFFSET = 32'h0000_0004;
    localparam logic [31:0] ARB_STATE_OFFSET = 32'h0000_0008;

    // ------------------------------------------------------------
    // Status word field positions
    // ------------------------------------------------------------
    localparam int CORE_PRIO_LO = 22;
    localparam int ROUND_SEL_BIT = 21;
    localparam int SAT_EN_BIT = 20;
    localparam int CACHE_EN_BIT = 19;
    localparam int RSVD_BIT = 18;
    localparam int NARROW_BIT = 17;
    localparam int FOREVER_BIT = 16;
    localparam int LOOP_BIT = 15;

    // ------------------------------------------------------------
    // Mode word field positions
    // ------------------------------------------------------------
    localparam int PRIO_MODE_LO = 0;
    localparam int BURST_BIT = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [1:0] CORE_PRIO_RST = 2'h3;
    localparam logic MODE_BIT_RST = 1'b0;
    localparam logic [1:0] PRIO_MODE_RST = 2'h0;

    // ------------------------------------------------------------
    // Accumulator limits and rounding constants
    // ------------------------------------------------------------
    localparam logic [55:0] SAT_MAX = 56'h00_7fff_ffff_ffff;
    localparam logic [55:0] SAT_MIN = 56'hff_8000_0000_0000;
    localparam logic [55:0] ROUND_HALF = 56'h00_0000_0080_0000;
    localparam logic [23:0] TIE_LOW = 24'h80_0000;
    localparam logic [23:0] LIM24_MAX = 24'h7f_ffff;
    localparam logic [23:0] LIM24_MIN = 24'h80_0000;
    localparam logic [23:0] LIM16_MAX = 24'h00_7fff;
    localparam logic [23:0] LIM16_MIN = 24'hff_8000;

    typedef enum logic [1:0] {
        PRIO_DYNAMIC = 2'b00,
        PRIO_CORE_LOW = 2'b01,
        PRIO_EQUAL = 2'b10,
        PRIO_CORE_HIGH = 2'b11
    } prio_mode_e;

    typedef enum logic [1:0] {
        LAST_CORE = 2'b01,
        LAST_DMA = 2'b10
    } rr_state_e;

    typedef struct packed {
        logic fv;
        logic lf;
    } loop_flags_s;

    typedef struct packed {
        logic [1:0] core_prio;
        logic round_twos;
        logic sat_en;
        logic cache_en;
        logic narrow_en;
        loop_flags_s flags;
    } mode_bits_s;

endpackage

//--- design/acc_result_shaper.sv
// Accumulator saturation, rounding and narrow-format limiting
`timescale 1ns/100ps
module acc_result_shaper
    import core_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [55:0] i_acc,
    input wire logic i_sat_en,
    input wire logic i_round_twos,
    input wire logic i_narrow_en,
    output logic [55:0] o_acc,
    output logic [23:0] o_msp
);
    logic ovf;
    logic [55:0] sat_val;
    logic [55:0] sum;
    logic tie;
    logic [55:0] rnd;
    logic [23:0] next_msp;

    assign ovf = ~(&i_acc[55:47] | ~(|i_acc[55:47]));
    assign sat_val = (i_sat_en && ovf) ? (i_acc[55] ? SAT_MIN : SAT_MAX) : i_acc;
    assign sum = sat_val + ROUND_HALF;
    assign tie = (sat_val[23:0] == TIE_LOW);

    always_comb begin
        rnd = sum;
        if (!i_round_twos && tie) begin
            rnd[24] = 1'b0;
        end
        if (i_narrow_en) begin
            if (&rnd[55:39] | ~(|rnd[55:39])) begin
                next_msp = {{8{rnd[39]}}, rnd[39:24]};
            end else begin
                next_msp = rnd[55] ? LIM16_MIN : LIM16_MAX;
            end
        end else if (&rnd[55:47] | ~(|rnd[55:47])) begin
            next_msp = rnd[47:24];
        end else begin
            next_msp = rnd[55] ? LIM24_MIN : LIM24_MAX;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_acc <= '0;
            o_msp <= '0;
        end else begin
            o_acc <= sat_val;
            o_msp <= next_msp;
        end
    end

    sat_pos_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_sat_en && ovf && !i_acc[55] |=> o_acc == SAT_MAX)
        else $error("saturation did not clamp to max");
    narrow_lim_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_narrow_en |=> o_msp[23:16] == {8{o_msp[15]}})
        else $error("narrow result not right aligned");
    conv_even_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_round_twos && !i_narrow_en && i_acc[55:47] == 9'h000
        && i_acc[23:0] == TIE_LOW && i_acc[46:24] != 23'h7f_ffff |=> !o_msp[0])
        else $error("convergent tie not rounded to even");
endmodule // acc_result_shaper

//--- design/bus_priority_arbiter.sv
// External bus arbitration between core and active DMA channel
`timescale 1ns/100ps
module bus_priority_arbiter
    import core_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire prio_mode_e i_mode,
    input wire logic [1:0] i_core_prio,
    input wire logic [1:0] i_dma_prio,
    input wire logic i_core_req,
    input wire logic i_dma_req,
    output logic o_core_grant,
    output logic o_dma_grant
);
    rr_state_e state;
    logic core_hi;
    logic dma_hi;

    always_comb begin
        case (i_mode)
            PRIO_CORE_LOW: begin
                core_hi = 1'b0;
                dma_hi = 1'b1;
            end
            PRIO_EQUAL: begin
                core_hi = 1'b0;
                dma_hi = 1'b0;
            end
            PRIO_CORE_HIGH: begin
                core_hi = 1'b1;
                dma_hi = 1'b0;
            end
            default: begin
                core_hi = i_core_prio > i_dma_prio;
                dma_hi = i_core_prio < i_dma_prio;
            end
        endcase
    end

    always_comb begin
        o_core_grant = 1'b0;
        o_dma_grant = 1'b0;
        if (i_core_req && i_dma_req) begin
            if (core_hi || (!dma_hi && state == LAST_DMA)) begin
                o_core_grant = 1'b1;
            end else begin
                o_dma_grant = 1'b1;
            end
        end else begin
            o_core_grant = i_core_req;
            o_dma_grant = i_dma_req;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= LAST_DMA;
        end else if (o_core_grant) begin
            state <= LAST_CORE;
        end else if (o_dma_grant) begin
            state <= LAST_DMA;
        end
    end

    static_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_mode == PRIO_CORE_LOW && i_core_req && i_dma_req |-> o_dma_grant && !o_core_grant)
        else $error("static low mode let core win");
    round_robin_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_mode == PRIO_EQUAL && i_core_req && i_dma_req && o_core_grant
        ##1 i_mode == PRIO_EQUAL && i_core_req && i_dma_req |-> o_dma_grant)
        else $error("equal priority did not alternate");
endmodule // bus_priority_arbiter

//--- design/core_status_mode_bits.sv
// Status word mode bits with AHB-Lite access, loop flag stacking and bus arbitration
`timescale 1ns/100ps
module core_status_mode_bits
    import core_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_loop_start,
    input wire logic i_forever_start,
    input wire logic i_loop_end,
    input wire logic i_rti_long,
    input wire loop_flags_s i_pop_flags,
    output logic o_push,
    output loop_flags_s o_push_flags,
    output mode_bits_s o_mode,
    output logic o_burst_en,
    input wire logic [55:0] i_acc,
    output logic [55:0] o_acc_sat,
    output logic [23:0] o_msp,
    input wire logic [1:0] i_dma_prio,
    input wire logic i_core_req,
    input wire logic i_dma_req,
    output logic o_core_grant,
    output logic o_dma_grant
);
    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic take;
    logic wr_pend;
    logic [31:0] wr_addr;
    logic wr_status;
    logic wr_mode;
    logic [1:0] core_prio;
    logic round_twos;
    logic sat_en;
    logic cache_en;
    logic narrow_en;
    loop_flags_s flags;
    mode_bits_s mode;
    prio_mode_e prio_mode;
    logic burst_en;
    logic [31:0] next_rdata;

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign take = i_hsel && i_hready && i_htrans[1];

    // ------------------------------------------------------------
    // Write capture
    // ------------------------------------------------------------
    // Address held over into the data phase
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_pend <= 1'b0;
            wr_addr <= '0;
        end else begin
            wr_pend <= take && i_hwrite && i_hsize == 3'h2;
            wr_addr <= i_haddr;
        end
    end

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Data-phase write strobes for the status and mode words
    assign wr_status = wr_pend && wr_addr == STATUS_WORD_OFFSET;
    assign wr_mode = wr_pend && wr_addr == MODE_WORD_OFFSET;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = '0;
        if (i_haddr == STATUS_WORD_OFFSET) begin
            next_rdata[CORE_PRIO_LO +: 2] = mode.core_prio;
            next_rdata[ROUND_SEL_BIT] = mode.round_twos;
            next_rdata[SAT_EN_BIT] = mode.sat_en;
            next_rdata[CACHE_EN_BIT] = mode.cache_en;
            next_rdata[NARROW_BIT] = mode.narrow_en;
            next_rdata[FOREVER_BIT] = mode.flags.fv;
            next_rdata[LOOP_BIT] = mode.flags.lf;
        end else if (i_haddr == MODE_WORD_OFFSET) begin
            next_rdata[PRIO_MODE_LO +: 2] = prio_mode;
            next_rdata[BURST_BIT] = burst_en;
        end else if (i_haddr == ARB_STATE_OFFSET) begin
            next_rdata[1:0] = {o_dma_grant, o_core_grant};
        end
    end

    // ------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------
    // Loaded in the address phase, stands until the next read
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= '0;
        end else if (take && !i_hwrite) begin
            o_hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Mode bits
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            core_prio <= CORE_PRIO_RST;
            round_twos <= MODE_BIT_RST;
            sat_en <= MODE_BIT_RST;
            cache_en <= MODE_BIT_RST;
            narrow_en <= MODE_BIT_RST;
        end else if (wr_status) begin
            core_prio <= i_hwdata[CORE_PRIO_LO +: 2];
            round_twos <= i_hwdata[ROUND_SEL_BIT];
            sat_en <= i_hwdata[SAT_EN_BIT];
            cache_en <= i_hwdata[CACHE_EN_BIT];
            narrow_en <= i_hwdata[NARROW_BIT];
        end
    end

    // Core view of the mode bits, loop flags included
    assign mode = {core_prio, round_twos, sat_en, cache_en, narrow_en, flags};

    // ------------------------------------------------------------
    // Mode word
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prio_mode <= prio_mode_e'(PRIO_MODE_RST);
            burst_en <= MODE_BIT_RST;
        end else if (wr_mode) begin
            prio_mode <= prio_mode_e'(i_hwdata[PRIO_MODE_LO +: 2]);
            burst_en <= i_hwdata[BURST_BIT];
        end
    end

    // ------------------------------------------------------------
    // Loop flags
    // ------------------------------------------------------------
    // Hardware loop events override a same-cycle software write
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            flags <= '0;
        end else if (i_forever_start) begin
            flags.fv <= 1'b1;
        end else if (i_loop_start) begin
            flags.lf <= 1'b1;
        end else if (i_loop_end || i_rti_long) begin
            flags <= i_pop_flags;
        end else if (wr_status) begin
            flags.fv <= i_hwdata[FOREVER_BIT];
            flags.lf <= i_hwdata[LOOP_BIT];
        end
    end

    // ------------------------------------------------------------
    // Stack interface
    // ------------------------------------------------------------
    // Flags stacked one cycle after a loop starts
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_push <= 1'b0;
            o_push_flags <= '0;
        end else begin
            o_push <= i_forever_start || i_loop_start;
            o_push_flags <= mode.flags;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_mode = mode;
    assign o_burst_en = burst_en;

    // ------------------------------------------------------------
    // Datapath: accumulator result shaper
    // ------------------------------------------------------------
    acc_result_shaper u_shaper (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_acc(i_acc),
        .i_sat_en(mode.sat_en),
        .i_round_twos(mode.round_twos),
        .i_narrow_en(mode.narrow_en),
        .o_acc(o_acc_sat),
        .o_msp(o_msp)
    );

    // ------------------------------------------------------------
    // Bus arbitration
    // ------------------------------------------------------------
    bus_priority_arbiter u_arb (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_mode(prio_mode),
        .i_core_prio(mode.core_prio),
        .i_dma_prio(i_dma_prio),
        .i_core_req(i_core_req),
        .i_dma_req(i_dma_req),
        .o_core_grant(o_core_grant),
        .o_dma_grant(o_dma_grant)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    round_sel_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_status |=> o_mode.round_twos == $past(i_hwdata[ROUND_SEL_BIT]))
        else $error("rounding select not written");
    sat_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_status ##1 !wr_status |-> o_mode.sat_en == $past(i_hwdata[SAT_EN_BIT], 1))
        else $error("saturation enable lost");
    cache_en_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_status |=> o_mode.cache_en == $past(i_hwdata[CACHE_EN_BIT]))
        else $error("cache enable not written");
    rsvd_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        take && !i_hwrite && i_haddr == STATUS_WORD_OFFSET |=> !o_hrdata[RSVD_BIT])
        else $error("reserved bit read nonzero");
    fv_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_forever_start |=> o_mode.flags.fv && o_push)
        else $error("forever flag not set");
    fv_push_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_forever_start |=> o_push_flags.fv == $past(mode.flags.fv))
        else $error("old forever flag not stacked");
    lf_restore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_loop_end && !i_forever_start && !i_loop_start |=> o_mode.flags == $past(i_pop_flags))
        else $error("loop flag not restored");
    rti_restore_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_rti_long && !i_forever_start && !i_loop_start
        |=> o_mode.flags.fv == $past(i_pop_flags.fv) && o_mode.flags.lf == $past(i_pop_flags.lf))
        else $error("interrupt return did not restore flags");
    narrow_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_status |=> o_mode.narrow_en == $past(i_hwdata[NARROW_BIT]))
        else $error("narrow mode not written");

    // ------------------------------------------------------------
    // Write, hold, stacking and readback checks
    // ------------------------------------------------------------
    prio_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_status |=> o_mode.core_prio == $past(i_hwdata[CORE_PRIO_LO +: 2]))
        else $error("core priority not written");

    mode_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        wr_mode |=> prio_mode == $past(i_hwdata[PRIO_MODE_LO +: 2]))
        else $error("priority mode not written");

    lf_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_loop_start && !i_forever_start |=> o_mode.flags.lf && o_push)
        else $error("loop flag not set");

    lf_push_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        i_loop_start |=> o_push_flags == $past(mode.flags))
        else $error("old loop flags not stacked");

    push_idle_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_forever_start && !i_loop_start |=> !o_push)
        else $error("push without a loop start");

    flags_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !i_forever_start && !i_loop_start && !i_loop_end && !i_rti_long && !wr_status
        |=> $stable(o_mode.flags))
        else $error("loop flags changed without an event");

    narrow_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !wr_status |=> $stable(o_mode.narrow_en))
        else $error("narrow mode changed without a write");

    sat_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !wr_status |=> $stable(o_mode.sat_en))
        else $error("saturation changed without a write");

    round_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !wr_status |=> $stable(o_mode.round_twos))
        else $error("rounding select changed without a write");

    cache_hold_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !wr_status |=> $stable(o_mode.cache_en))
        else $error("cache enable changed without a write");

    status_read_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        take && !i_hwrite && i_haddr == STATUS_WORD_OFFSET
        |=> o_hrdata[LOOP_BIT +: 2] == $past(mode.flags))
        else $error("loop flags read back wrong");
endmodule // core_status_mode_bits

//--- test/core_status_mode_bits_tb.sv
// Self-checking bench for the status word mode bits block
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module core_status_mode_bits_tb
    import core_status_pkg::*;
;
    logic i_clk, i_rst_n, i_hsel, i_hwrite, hready;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, rdata;
    logic [1:0] i_htrans, i_dma_prio;
    logic [2:0] i_hsize;
    logic o_hresp, o_push, o_burst_en, o_core_grant, o_dma_grant, g0;
    logic i_loop_start, i_forever_start, i_loop_end, i_rti_long, i_core_req, i_dma_req;
    loop_flags_s i_pop_flags, o_push_flags;
    mode_bits_s o_mode;
    logic [55:0] i_acc, o_acc_sat;
    logic [23:0] o_msp;
    int num_errors = 0;
    int checked = 0;

    core_status_mode_bits core_status_mode_bits_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr),
        .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
        .i_hready(hready), .o_hrdata(o_hrdata), .o_hreadyout(hready), .o_hresp(o_hresp),
        .i_loop_start(i_loop_start), .i_forever_start(i_forever_start),
        .i_loop_end(i_loop_end), .i_rti_long(i_rti_long), .i_pop_flags(i_pop_flags),
        .o_push(o_push), .o_push_flags(o_push_flags), .o_mode(o_mode),
        .o_burst_en(o_burst_en), .i_acc(i_acc), .o_acc_sat(o_acc_sat), .o_msp(o_msp),
        .i_dma_prio(i_dma_prio), .i_core_req(i_core_req), .i_dma_req(i_dma_req),
        .o_core_grant(o_core_grant), .o_dma_grant(o_dma_grant)
    );

    // ------------------------------------------------------------
    // Clock, closing and watchdog
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        num_errors++;
        tally_and_finish();
    end

    // ------------------------------------------------------------
    // Bus and event helpers
    // ------------------------------------------------------------
    task automatic ahb_xfer(input logic [31:0] a, input logic w, input logic [31:0] wd);
        i_hsel <= 1'b1;
        i_haddr <= a;
        i_hwrite <= w;
        i_htrans <= 2'b10;
        i_hsize <= 3'b010;
        do @(posedge i_clk); while (hready !== 1'b1);
        i_htrans <= 2'b00;
        i_hsel <= 1'b0;
        i_hwdata <= wd;
        do @(posedge i_clk); while (hready !== 1'b1);
        rdata = o_hrdata;
        @(posedge i_clk);
        #1;
    endtask

    task automatic loop_event(input logic [3:0] sel, input logic [1:0] pop,
                              input logic [1:0] exp_flags, input logic exp_push,
                              input logic [1:0] exp_pushed);
        {i_forever_start, i_loop_start, i_loop_end, i_rti_long} <= sel;
        i_pop_flags <= loop_flags_s'(pop);
        @(posedge i_clk);
        {i_forever_start, i_loop_start, i_loop_end, i_rti_long} <= 4'h0;
        #1;
        `CHK("loop flags", exp_flags, o_mode.flags)
        `CHK("push pulse", exp_push, o_push)
        if (exp_push) `CHK("pushed flags", exp_pushed, o_push_flags)
    endtask

    task automatic acc_check(input logic [55:0] acc, input logic [55:0] exp_acc,
                             input logic [23:0] exp_msp);
        i_acc <= acc;
        @(posedge i_clk);
        #1;
        `CHK("accumulator", exp_acc, o_acc_sat)
        `CHK("rounded part", exp_msp, o_msp)
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic reset_and_map();
        `CHK("mode at reset", mode_bits_s'({CORE_PRIO_RST, 6'h00}), o_mode)
        `CHK("bus ready and okay", 2'b10, {hready, o_hresp})
        ahb_xfer(STATUS_WORD_OFFSET, 1'b0, 32'h0000_0000);
        `CHK("status at reset", 32'h00c0_0000, rdata)
        ahb_xfer(32'h0000_0010, 1'b0, 32'h0000_0000);
        `CHK("unmapped read", 32'h0000_0000, rdata)
    endtask

    task automatic status_bits();
        ahb_xfer(STATUS_WORD_OFFSET, 1'b1, 32'h003b_8000);
        `CHK("mode after write", mode_bits_s'(8'h3f), o_mode)
        ahb_xfer(STATUS_WORD_OFFSET, 1'b0, 32'h0000_0000);
        `CHK("status readback", 32'h003b_8000, rdata)
        ahb_xfer(MODE_WORD_OFFSET, 1'b1, 32'h0000_0007);
        ahb_xfer(MODE_WORD_OFFSET, 1'b0, 32'h0000_0000);
        `CHK("mode word", 32'h0000_0007, rdata)
        `CHK("burst level", 1'b1, o_burst_en)
        ahb_xfer(MODE_WORD_OFFSET, 1'b1, 32'h0000_0000);
        ahb_xfer(STATUS_WORD_OFFSET, 1'b1, 32'h0000_0000);
        `CHK("mode cleared", mode_bits_s'(8'h00), o_mode)
    endtask

    task automatic loop_nesting();
        loop_event(4'h8, 2'b00, 2'b10, 1'b1, 2'b00);
        loop_event(4'h0, 2'b00, 2'b10, 1'b0, 2'b00);
        loop_event(4'h4, 2'b00, 2'b11, 1'b1, 2'b10);
        loop_event(4'h2, 2'b10, 2'b10, 1'b0, 2'b00);
        loop_event(4'h1, 2'b01, 2'b01, 1'b0, 2'b00);
        loop_event(4'h2, 2'b00, 2'b00, 1'b0, 2'b00);
    endtask

    task automatic mid_reset();
        ahb_xfer(STATUS_WORD_OFFSET, 1'b1, 32'h0003_8000);
        `CHK("mode before reset", mode_bits_s'(8'h07), o_mode)
        i_rst_n <= 1'b0;
        @(posedge i_clk);
        #1;
        `CHK("mode in reset", mode_bits_s'({CORE_PRIO_RST, 6'h00}), o_mode)
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1;
        `CHK("mode after reset", mode_bits_s'({CORE_PRIO_RST, 6'h00}), o_mode)
    endtask

    task automatic accumulator();
        acc_check(56'h00_8000_0000_0000, 56'h00_8000_0000_0000, 24'h7f_ffff);
        acc_check(56'h00_0000_0080_0000, 56'h00_0000_0080_0000, 24'h00_0000);
        acc_check(56'h00_0000_0180_0000, 56'h00_0000_0180_0000, 24'h00_0002);
        ahb_xfer(STATUS_WORD_OFFSET, 1'b1, 32'h0030_0000);
        acc_check(56'h00_0000_0080_0000, 56'h00_0000_0080_0000, 24'h00_0001);
        acc_check(56'h00_8000_0000_0000, SAT_MAX, 24'h7f_ffff);
        acc_check(56'hf0_0000_0000_0000, SAT_MIN, 24'h80_0000);
        ahb_xfer(STATUS_WORD_OFFSET, 1'b1, 32'h0002_0000);
        acc_check(56'h00_0000_1234_0000, 56'h00_0000_1234_0000, 24'h00_0012);
        acc_check(56'h00_0080_0000_0000, 56'h00_0080_0000_0000, 24'h00_7fff);
        acc_check(56'hff_ff00_0000_0000, 56'hff_ff00_0000_0000, 24'hff_8000);
        ahb_xfer(STATUS_WORD_OFFSET, 1'b1, 32'h0000_0000);
    endtask

    task automatic arbitration();
        i_core_req <= 1'b1;
        i_dma_req <= 1'b1;
        i_dma_prio <= 2'h1;
        ahb_xfer(STATUS_WORD_OFFSET, 1'b1, 32'h00c0_0000);
        `CHK("dynamic core wins", 2'b10, {o_core_grant, o_dma_grant})
        ahb_xfer(MODE_WORD_OFFSET, 1'b1, 32'h0000_0001);
        `CHK("static core low", 2'b01, {o_core_grant, o_dma_grant})
        ahb_xfer(ARB_STATE_OFFSET, 1'b0, 32'h0000_0000);
        `CHK("grant readback", 32'h0000_0002, rdata)
        ahb_xfer(MODE_WORD_OFFSET, 1'b1, 32'h0000_0003);
        i_dma_prio <= 2'h3;
        ahb_xfer(STATUS_WORD_OFFSET, 1'b1, 32'h0000_0000);
        `CHK("static core high", 2'b10, {o_core_grant, o_dma_grant})
        ahb_xfer(MODE_WORD_OFFSET, 1'b1, 32'h0000_0000);
        `CHK("dynamic dma wins", 2'b01, {o_core_grant, o_dma_grant})
        ahb_xfer(MODE_WORD_OFFSET, 1'b1, 32'h0000_0002);
        g0 = o_core_grant;
        `CHK("one grant", 1'b1, o_core_grant ^ o_dma_grant)
        @(posedge i_clk);
        #1;
        `CHK("turn taking", {~g0, g0}, {o_core_grant, o_dma_grant})
        i_core_req <= 1'b0;
        i_dma_req <= 1'b0;
        @(posedge i_clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        i_rst_n = 1'b0;
        i_hsel = 1'b0;
        i_haddr = 32'h0000_0000;
        i_htrans = 2'b00;
        i_hwrite = 1'b0;
        i_hsize = 3'b010;
        i_hwdata = 32'h0000_0000;
        {i_forever_start, i_loop_start, i_loop_end, i_rti_long} = 4'h0;
        i_pop_flags = loop_flags_s'(2'b00);
        i_acc = 56'h00_0000_0000_0000;
        i_dma_prio = 2'h0;
        i_core_req = 1'b0;
        i_dma_req = 1'b0;
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1;
        reset_and_map();
        status_bits();
        loop_nesting();
        mid_reset();
        accumulator();
        arbitration();
        tally_and_finish();
    end
endmodule // core_status_mode_bits_tb
